// [src/cil_pkg.sv]
// Purpose: Constants and types for the common inversion and line address block
// Assumes: 10 MHz pclk, APB register access, pins sampled asynchronously
// Notes: Frame is 8 header bits, then per line 8 address bits, 320 data
//   bits and 8 dummy bits, all shifted on rising serial clock edges.
// Summary of operation
// - Source select low uses frame polarity flag; high uses polarity clock.
// - Frame source: common electrode follows the received polarity flag.
// - External source, select high: polarity changes on rising edge.
// - External source, select low: polarity also changes on rising edge.
// - Line address is 8 bits, bit 0 least significant, plain binary.
// - Valid lines are 1 to 240; other addresses select no line.
// - Array is 320 columns by 240 rows; each line has 320 bits.
// - Polarity flag ignored while source select is high.
// - Falling serial select clears update mode and clear-all flags.
package cil_pkg;
  localparam logic [31:0] CIL_OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] CIL_OFS_STATUS = 32'h0000_0004;
  localparam logic [31:0] CIL_OFS_LINES = 32'h0000_0008;
  localparam int CIL_CTRL_EN_BIT = 0;
  localparam logic CIL_CTRL_EN_RST = 1'b1;
  localparam int CIL_ST_UPD_BIT = 0;
  localparam int CIL_ST_POLF_BIT = 1;
  localparam int CIL_ST_CLR_BIT = 2;
  localparam int CIL_ST_SRC_BIT = 3;
  localparam int CIL_ST_IPOL_BIT = 4;
  localparam int CIL_ST_COM_BIT = 5;
  localparam int CIL_ST_AVAL_BIT = 6;
  localparam int CIL_ST_ADDR_LSB = 8;
  localparam logic [8:0] CIL_HDR_BITS = 9'h008;
  localparam logic [8:0] CIL_ADDR_BITS = 9'h008;
  localparam logic [8:0] CIL_LINE_BITS = 9'h140;
  localparam logic [8:0] CIL_DUMMY_BITS = 9'h008;
  localparam logic [7:0] CIL_LINE_FIRST = 8'h01;
  localparam logic [7:0] CIL_LINE_LAST = 8'hF0;
  localparam int CIL_IN_SCS = 0;
  localparam int CIL_IN_SCLK = 1;
  localparam int CIL_IN_SDI = 2;
  localparam int CIL_IN_EXT = 3;
  localparam int CIL_IN_SRC = 4;

  typedef enum logic [2:0] {
    CIL_IDLE = 3'b000,
    CIL_HDR = 3'b001,
    CIL_ADDR = 3'b010,
    CIL_DATA = 3'b011,
    CIL_DUMMY = 3'b100
  } cil_phase_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } cil_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cil_apb_rsp_s;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic sclk_prev;
    logic ext_prev;
    logic scs_prev;
    cil_phase_e phase;
    logic [8:0] cnt;
    logic update_mode_flag;
    logic polarity_flag;
    logic clear_all_flag;
    logic [7:0] addr_shift;
    logic [7:0] line_addr;
    logic addr_valid;
    logic [7:0] lines_done;
    logic internal_polarity_signal;
    logic common_electrode_level;
    logic ctrl_en;
    cil_apb_rsp_s rsp;
  } cil_state_s;

  function automatic logic cil_line_ok(input logic [7:0] a);
    return (a >= CIL_LINE_FIRST) && (a <= CIL_LINE_LAST);
  endfunction : cil_line_ok
endpackage : cil_pkg

// [src/cil_core.sv]
// Purpose: Common polarity source choice and gate line address capture
// Assumes: Serial and polarity pins asynchronous to pclk; serial clock
//   well below pclk so every edge is seen after synchronising
// Notes: Registers on APB with one wait state per access
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cil_core
  import cil_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire cil_apb_req_s apb_req,
  output cil_apb_rsp_s apb_rsp,
  input wire logic serial_select,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic external_polarity_clock,
  input wire logic inversion_source_select,
  output logic common_electrode_level,
  output logic [7:0] line_address_bits,
  output logic line_address_valid
);
  cil_state_s q;
  cil_state_s d;
  logic sclk_rise;
  logic ext_rise;
  logic scs_fall;
  logic scs_on;
  logic src_ext;
  logic sdi;
  logic line_end;
  logic addr_done;
  logic apb_done;

  assign scs_on = q.s2[CIL_IN_SCS];
  assign src_ext = q.s2[CIL_IN_SRC];
  assign sdi = q.s2[CIL_IN_SDI];
  assign sclk_rise = q.s2[CIL_IN_SCLK] & ~q.sclk_prev & scs_on;
  assign ext_rise = q.s2[CIL_IN_EXT] & ~q.ext_prev;
  assign scs_fall = q.scs_prev & ~scs_on;
  assign addr_done = sclk_rise && (q.phase == CIL_ADDR)
    && (q.cnt == CIL_ADDR_BITS - 9'h001);
  assign line_end = sclk_rise && (q.phase == CIL_DATA)
    && (q.cnt == CIL_LINE_BITS - 9'h001) && q.addr_valid;
  assign apb_done = apb_req.psel & apb_req.penable & q.rsp.pready;

  always_comb begin
    d = q;
    d.s1 = {inversion_source_select, external_polarity_clock, serial_data,
      serial_clock, serial_select};
    d.s2 = q.s1;
    d.sclk_prev = q.s2[CIL_IN_SCLK];
    d.ext_prev = q.s2[CIL_IN_EXT];
    d.scs_prev = scs_on;
    // Frame parsing, one bit per rising serial clock edge
    if (!scs_on) begin
      d.phase = CIL_IDLE;
      d.cnt = 9'h000;
    end else if (q.phase == CIL_IDLE) begin
      d.phase = CIL_HDR;
      d.cnt = 9'h000;
    end
    if (sclk_rise) begin
      d.cnt = q.cnt + 9'h001;
      unique case (q.phase)
        CIL_IDLE, CIL_HDR: begin
          if (q.cnt == 9'h000) begin
            d.update_mode_flag = sdi;
          end
          if (q.cnt == 9'h001) begin
            d.polarity_flag = sdi;
          end
          if (q.cnt == 9'h002) begin
            d.clear_all_flag = sdi;
          end
          if (q.cnt == CIL_HDR_BITS - 9'h001) begin
            d.phase = CIL_ADDR;
            d.cnt = 9'h000;
          end
        end
        CIL_ADDR: begin
          // Bit 0 arrives first, so shift in from the top
          d.addr_shift = {sdi, q.addr_shift[7:1]};
          if (addr_done) begin
            d.line_addr = {sdi, q.addr_shift[7:1]};
            d.addr_valid = cil_line_ok(d.line_addr);
            d.phase = CIL_DATA;
            d.cnt = 9'h000;
          end
        end
        CIL_DATA: begin
          // Pixel bits are counted only; storage lives in the pixel array
          if (q.cnt == CIL_LINE_BITS - 9'h001) begin
            d.phase = CIL_DUMMY;
            d.cnt = 9'h000;
          end
        end
        CIL_DUMMY: begin
          if (q.cnt == CIL_DUMMY_BITS - 9'h001) begin
            d.phase = CIL_ADDR;
            d.cnt = 9'h000;
          end
        end
        default: begin
          d.phase = CIL_IDLE;
        end
      endcase
    end
    if (line_end) begin
      d.lines_done = q.lines_done + 8'h01;
    end
    if (scs_fall) begin
      d.update_mode_flag = 1'b0;
      d.clear_all_flag = 1'b0;
    end
    // External clock acts in both select states alike
    if (src_ext && ext_rise) begin
      d.internal_polarity_signal = ~q.internal_polarity_signal;
    end
    // Flag is ignored while the external source is chosen
    if (!q.ctrl_en) begin
      d.common_electrode_level = 1'b0;
    end else if (src_ext) begin
      d.common_electrode_level = q.internal_polarity_signal;
    end else begin
      d.common_electrode_level = q.polarity_flag;
    end
    // APB slave: one wait state, pready pulses for one cycle
    d.rsp.pready = apb_req.psel & apb_req.penable & ~q.rsp.pready;
    d.rsp.pslverr = 1'b0;
    if (apb_req.psel && apb_req.penable && !q.rsp.pready) begin
      d.rsp.prdata = 32'h0000_0000;
      unique case (apb_req.paddr)
        CIL_OFS_CTRL: begin
          d.rsp.prdata[CIL_CTRL_EN_BIT] = q.ctrl_en;
        end
        CIL_OFS_STATUS: begin
          d.rsp.prdata[CIL_ST_UPD_BIT] = q.update_mode_flag;
          d.rsp.prdata[CIL_ST_POLF_BIT] = q.polarity_flag;
          d.rsp.prdata[CIL_ST_CLR_BIT] = q.clear_all_flag;
          d.rsp.prdata[CIL_ST_SRC_BIT] = src_ext;
          d.rsp.prdata[CIL_ST_IPOL_BIT] = q.internal_polarity_signal;
          d.rsp.prdata[CIL_ST_COM_BIT] = q.common_electrode_level;
          d.rsp.prdata[CIL_ST_AVAL_BIT] = q.addr_valid;
          d.rsp.prdata[CIL_ST_ADDR_LSB +: 8] = q.line_addr;
        end
        CIL_OFS_LINES: begin
          d.rsp.prdata[7:0] = q.lines_done;
        end
        default: begin
          d.rsp.pslverr = 1'b1;
        end
      endcase
    end
    // Writes land only at the completing edge
    if (apb_done && apb_req.pwrite) begin
      if (apb_req.paddr == CIL_OFS_CTRL) begin
        d.ctrl_en = apb_req.pwdata[CIL_CTRL_EN_BIT];
      end else if (apb_req.paddr == CIL_OFS_LINES) begin
        d.lines_done = line_end ? 8'h01 : 8'h00;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl_en <= CIL_CTRL_EN_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign apb_rsp = q.rsp;
  assign common_electrode_level = q.common_electrode_level;
  assign line_address_bits = q.line_addr;
  assign line_address_valid = q.addr_valid;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_FRAME_SOURCE: assert property (
    ce && q.ctrl_en && !src_ext
    |=> common_electrode_level == $past(q.polarity_flag))
    else $error("common level does not follow polarity flag");

  AST_EXT_SOURCE: assert property (
    ce && q.ctrl_en && src_ext
    |=> common_electrode_level == $past(q.internal_polarity_signal))
    else $error("common level does not follow internal polarity");

  AST_EXT_EDGE: assert property (
    ce && src_ext && ext_rise
    |=> q.internal_polarity_signal != $past(q.internal_polarity_signal))
    else $error("polarity missed external clock edge");

  AST_FRAME_HOLD: assert property (
    ce && !src_ext |=> $stable(q.internal_polarity_signal))
    else $error("polarity moved with frame source selected");

  AST_SCS_CLEAR: assert property (
    ce && scs_fall |=> !q.update_mode_flag && !q.clear_all_flag)
    else $error("mode flags not cleared on select fall");

  AST_ADDR_RANGE: assert property (
    line_address_valid |-> line_address_bits >= 8'h01
    && line_address_bits <= 8'hF0)
    else $error("valid address outside line range");

  AST_ADDR_ORDER: assert property (
    ce && addr_done |=> line_address_bits
    == {$past(sdi), $past(q.addr_shift[7:1])})
    else $error("line address assembled wrongly");

  AST_LINE_COUNT: assert property (
    ce && line_end && !apb_done
    |=> q.lines_done == $past(q.lines_done) + 8'h01)
    else $error("completed line not counted");

  // Edges with select high and low are checked apart so both stay covered
  AST_EXT_SEL_HIGH: assert property (
    ce && src_ext && ext_rise && scs_on
    |=> q.internal_polarity_signal != $past(q.internal_polarity_signal))
    else $error("polarity missed edge with select high");

  AST_EXT_SEL_LOW: assert property (
    ce && src_ext && ext_rise && !scs_on
    |=> q.internal_polarity_signal != $past(q.internal_polarity_signal))
    else $error("polarity missed edge with select low");

  AST_EXT_QUIET: assert property (
    ce && !ext_rise |=> $stable(q.internal_polarity_signal))
    else $error("polarity moved without an external edge");

  AST_COM_OFF: assert property (
    ce && !q.ctrl_en |=> !common_electrode_level)
    else $error("common level high while output disabled");

  // With the clock source chosen a flag change must not reach the output
  AST_FLAG_KEEP: assert property (
    ce && q.ctrl_en && src_ext && !ext_rise
    ##1 ce && q.ctrl_en && src_ext
    |=> $stable(common_electrode_level))
    else $error("common level moved with clock source chosen");

  AST_UPD_FLAG: assert property (
    ce && sclk_rise && q.phase == CIL_HDR && q.cnt == 9'h000
    |=> q.update_mode_flag == $past(sdi))
    else $error("update flag not taken from first header bit");

  AST_HDR_FLAG: assert property (
    ce && sclk_rise && q.phase == CIL_HDR && q.cnt == 9'h001
    |=> q.polarity_flag == $past(sdi))
    else $error("polarity flag not taken from second header bit");

  AST_CLR_FLAG: assert property (
    ce && sclk_rise && q.phase == CIL_HDR && q.cnt == 9'h002
    |=> q.clear_all_flag == $past(sdi))
    else $error("clear flag not taken from third header bit");

  AST_ADDR_HOLD: assert property (
    ce && !addr_done |=> $stable(line_address_bits))
    else $error("line address moved between address fields");

  AST_ADDR_ACCEPT: assert property (
    ce && addr_done |=> line_address_valid
    == (line_address_bits >= CIL_LINE_FIRST
    && line_address_bits <= CIL_LINE_LAST))
    else $error("in-range line address not accepted");

  AST_ADDR_NOSEL: assert property (
    line_address_bits == 8'h00 |-> !line_address_valid)
    else $error("address zero marked valid");

  AST_SCS_PHASE: assert property (
    ce && !scs_on |=> q.phase == CIL_IDLE)
    else $error("frame parser not reset with select low");

  AST_FLAGS_HOLD: assert property (
    ce && scs_on && !sclk_rise
    |=> $stable(q.update_mode_flag) && $stable(q.clear_all_flag))
    else $error("mode flags moved without a serial edge");

  // A line ending in the same cycle as the clear loads 1 and is checked neither here nor by LINE_COUNT
  AST_LINES_CLEAR: assert property (
    ce && apb_done && apb_req.pwrite && apb_req.paddr == CIL_OFS_LINES
    && !line_end |=> q.lines_done == 8'h00)
    else $error("line count not cleared by write");

  COV_EXT_TOGGLE: cover property (ce && src_ext && ext_rise);
  COV_EXT_SEL_HIGH: cover property (ce && src_ext && ext_rise && scs_on);
  COV_LINE_DONE: cover property (ce && line_end);
  COV_SCS_CLEAR: cover property (ce && scs_fall && q.update_mode_flag);
  COV_LAST_LINE: cover property (ce && addr_done
    && {sdi, q.addr_shift[7:1]} == 8'hF0);
endmodule : cil_core
`default_nettype wire

// [verification/cil_host.sv]
// Purpose: Host model driving the serial and polarity pins
// Assumes: Serial clock of 800 ns made from pclk edges
// Notes: Serial clock idles low between frames
`timescale 1ns/1ps
`default_nettype none
module cil_host (
  input wire logic pclk,
  output logic serial_select,
  output logic serial_clock,
  output logic serial_data,
  output logic external_polarity_clock,
  output logic inversion_source_select
);
  logic last_q;
  initial begin
    serial_select = 1'b0;
    serial_clock = 1'b0;
    serial_data = 1'b1;
    external_polarity_clock = 1'b0;
    inversion_source_select = 1'b0;
    last_q = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_n
  task automatic set_src(input logic v);
    inversion_source_select <= v;
    wait_n(4);
  endtask : set_src
  task automatic open_frame();
    serial_select <= 1'b1;
    wait_n(8);
  endtask : open_frame
  // Data held 400 ns past the rising edge, well over the hold need
  task automatic put_bit(input logic b);
    serial_data <= b;
    serial_clock <= 1'b0;
    wait_n(4);
    serial_clock <= 1'b1;
    wait_n(4);
    last_q = b;
  endtask : put_bit
  task automatic put_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      put_bit(v[i]);
    end
  endtask : put_byte
  task automatic put_fill(input int n, input logic v);
    repeat (n) put_bit(v);
  endtask : put_fill
  // Released data line shows the inverse so a stale value cannot pass
  task automatic close_frame();
    serial_clock <= 1'b0;
    wait_n(4);
    serial_select <= 1'b0;
    serial_data <= ~last_q;
    wait_n(8);
  endtask : close_frame
  // Equal halves, fixed period of 1600 ns, two serial clock periods
  task automatic ext_pulse();
    external_polarity_clock <= 1'b1;
    wait_n(8);
    external_polarity_clock <= 1'b0;
    wait_n(8);
  endtask : ext_pulse
endmodule : cil_host
`default_nettype wire

// [verification/com_inversion_line_addressing_tb.sv]
// Purpose: Self-checking bench for the polarity and line address block
// Assumes: Host model drives the serial and polarity pins; ce held high except one frozen span in t_ext
// Notes: APB master waits on pready without a bound; only the watchdog ends a stuck access
`timescale 1ns/1ps
`default_nettype none
module com_inversion_line_addressing_tb import cil_pkg::*;;
  logic pclk, presetn, ce, ssel, sclk, sdat, extc, srcs, com, aval, er;
  logic [7:0] la;
  logic [31:0] rd;
  logic [7:0] adr [5] = '{8'h01, 8'hF0, 8'h00, 8'hF1, 8'h5A};
  logic adr_ok [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  cil_apb_req_s req;
  cil_apb_rsp_s rsp;
  int bad_count, total_checks;
  cil_core u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req),
    .apb_rsp(rsp), .serial_select(ssel), .serial_clock(sclk),
    .serial_data(sdat), .external_polarity_clock(extc),
    .inversion_source_select(srcs), .common_electrode_level(com),
    .line_address_bits(la), .line_address_valid(aval));
  cil_host u_host (.pclk(pclk), .serial_select(ssel), .serial_clock(sclk),
    .serial_data(sdat), .external_polarity_clock(extc),
    .inversion_source_select(srcs));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    // No bound here: only the watchdog may end a stuck access
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1);
    chk("wait_states", 2, n);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask : apb
  task automatic t_regs();
    apb(1'b0, CIL_OFS_CTRL, 0);
    chk("ctrl_reset", 1, rd);
    apb(1'b0, 32'h0000_0010, 0);
    chk("unmapped_err", 1, 32'(er));
    chk("unmapped_rd", 0, rd);
  endtask : t_regs
  task automatic t_flag();
    for (int p = 1; p >= 0; p--) begin
      u_host.open_frame();
      u_host.put_byte({5'h00, 1'b1, p[0], 1'b1});
      apb(1'b0, CIL_OFS_STATUS, 0);
      chk("flags_in", 32'h5, rd & 32'h5);
      u_host.close_frame();
      chk("com_flag", 32'(p), 32'(com));
      apb(1'b0, CIL_OFS_STATUS, 0);
      chk("flags_out", 0, rd & 32'h5);
    end
  endtask : t_flag
  task automatic t_addr();
    foreach (adr[i]) begin
      u_host.open_frame();
      u_host.put_byte(8'h01);
      u_host.put_byte(adr[i]);
      u_host.close_frame();
      chk("line_addr", 32'(adr[i]), 32'(la));
      chk("line_ok", 32'(adr_ok[i]), 32'(aval));
    end
  endtask : t_addr
  // Ones in the pixel data expose a miscounted line length
  task automatic t_lines();
    u_host.open_frame();
    u_host.put_byte(8'h01);
    u_host.put_byte(8'h02);
    u_host.put_fill(320, 1'b1);
    u_host.put_fill(8, 1'b0);
    u_host.put_byte(8'h03);
    u_host.close_frame();
    chk("second_line", 32'h3, 32'(la));
    apb(1'b0, CIL_OFS_LINES, 0);
    chk("lines_done", 1, rd);
    apb(1'b1, CIL_OFS_LINES, 32'h0000_00FF);
    apb(1'b0, CIL_OFS_LINES, 0);
    chk("lines_clear", 0, rd);
  endtask : t_lines
  task automatic t_ext();
    u_host.ext_pulse();
    chk("ext_ignored", 0, 32'(com));
    apb(1'b0, CIL_OFS_STATUS, 0);
    chk("ipol_ignored", 0, 32'(rd[CIL_ST_IPOL_BIT]));
    u_host.set_src(1'b1);
    u_host.ext_pulse();
    chk("ext_sel_low", 1, 32'(com));
    // A pulse wholly inside a frozen span must leave no trace
    ce <= 1'b0;
    u_host.ext_pulse();
    ce <= 1'b1;
    u_host.wait_n(4);
    chk("ce_freeze", 1, 32'(com));
    apb(1'b1, CIL_OFS_CTRL, 0);
    u_host.wait_n(2);
    chk("com_off", 0, 32'(com));
    apb(1'b1, CIL_OFS_CTRL, 1);
    u_host.wait_n(2);
    chk("com_on", 1, 32'(com));
    u_host.open_frame();
    u_host.put_byte(8'h00);
    u_host.wait_n(4);
    chk("flag_ignored", 1, 32'(com));
    u_host.ext_pulse();
    chk("ext_sel_high", 0, 32'(com));
    u_host.close_frame();
  endtask : t_ext
  task automatic t_reset();
    apb(1'b1, CIL_OFS_CTRL, 0);
    presetn <= 1'b0;
    u_host.wait_n(2);
    presetn <= 1'b1;
    u_host.wait_n(1);
    chk("com_rst", 0, 32'(com));
    chk("addr_rst", 0, 32'(la));
    apb(1'b0, CIL_OFS_CTRL, 0);
    chk("ctrl_rst", 1, rd);
  endtask : t_reset
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    req = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("com_reset", 0, 32'(com));
    t_regs();
    t_flag();
    t_addr();
    t_lines();
    t_ext();
    t_reset();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done();
  end
endmodule : com_inversion_line_addressing_tb
`default_nettype wire
